/* design/dbf_core.sv */
`timescale 1ns/1ps
// Function
// - writes to read-only control nibbles ignored
// - unused control nibbles: any read, inert writes
// - buffer is nibbles 0ch to 0fh
// - bit 0 of 0fh is lsb
// - buffer nibbles are ordinary memory cells
// - fetch copies peripheral into buffer
// - store copies buffer into peripheral
// - fetch of store-only gives arbitrary value
// - store to fetch-only is a no-operation
// - serial 01h rw, count 02h, reload 03h
// - table pointer at 40h, 10 bits, rw
// - transfers are 8 or 16 bits
// - both widths take the same cycles
// - narrow store uses low byte only
// - narrow fetch keeps upper two nibbles
// - table lookup loads program word into buffer
// - register file reached through window at 78h
// - register file 40h-7fh is data memory
module dbf_core #(
  parameter logic [63:0] CTRL_USED = dbf_pkg::CTRL_USED_DEF,  // existing control nibbles
  parameter logic [63:0] CTRL_RO   = dbf_pkg::CTRL_RO_DEF     // read-only control nibbles
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // request from the cpu core
  input  wire dbf_pkg::dbf_op_t op,
  input  wire logic [6:0]       addr,
  input  wire logic [3:0]       wdata,
  output logic      [3:0]       rdata,
  output logic                  done,
  // peripheral registers
  input  wire logic [7:0]       timer_live_count,
  output logic      [7:0]       serial_shift_data,
  output logic      [7:0]       timer_reload_limit,
  output logic      [9:0]       table_pointer,
  // program memory word at table_pointer
  input  wire logic [15:0]      rom_data,
  // control area towards the peripherals
  input  wire logic [255:0]     ctrl_status,
  output logic      [255:0]     ctrl_out,
  // buffer view
  output logic      [15:0]      transfer_buffer
);

  // state of the first memory bank and the answer registers
  typedef struct packed {
    logic [127:0][3:0] mem;    // data memory, buffer and window included
    logic [3:0]        rdata;  // read answer
    logic              done;   // completion pulse
  } dbf_core_st_t;

  dbf_core_st_t s;       // registered state
  dbf_core_st_t next_s;  // next state

  logic [15:0] buf_val;     // buffer as one word
  logic        ctrl_hit;    // register file address lies in the control area
  logic [15:0] p_rdata;     // peripheral fetch value
  logic        p_wide;      // selected peripheral is 16 bits
  logic        p_we;        // store strobe to the peripherals
  logic [3:0]  c_rdata;     // control area read value
  logic        c_we;        // control area write strobe
  logic [3:0]  shared_val;  // memory nibble seen through the shared view

  // buffer word assembled from its four nibbles, top one most significant
  always_comb begin
    buf_val = {s.mem[dbf_pkg::BUF_TOP_ADDR], s.mem[dbf_pkg::BUF_UMID_ADDR],
               s.mem[dbf_pkg::BUF_LMID_ADDR], s.mem[dbf_pkg::BUF_LOW_ADDR]};
  end

  // register file address split
  assign ctrl_hit   = (addr < dbf_pkg::SHARED_BASE);
  assign shared_val = s.mem[addr];

  // strobes towards the two submodules
  assign p_we = (op == dbf_pkg::OP_STORE);
  assign c_we = (op == dbf_pkg::OP_RF_WRITE) && ctrl_hit;

  // peripheral registers and their store/fetch decode
  dbf_periph u_periph (
    .clock              (clock),
    .rst_b              (rst_b),
    .we                 (p_we),
    .addr               (addr),
    .wdata              (buf_val),
    .rdata              (p_rdata),
    .wide               (p_wide),
    .timer_live_count   (timer_live_count),
    .serial_shift_data  (serial_shift_data),
    .timer_reload_limit (timer_reload_limit),
    .table_pointer      (table_pointer)
  );

  // control register area with read-only and unused handling
  dbf_ctrl_area #(
    .USED (CTRL_USED),
    .RO   (CTRL_RO)
  ) u_ctrl (
    .clock       (clock),
    .rst_b       (rst_b),
    .we          (c_we),
    .addr        (addr[5:0]),
    .wdata       (s.mem[dbf_pkg::WINDOW_ADDR]),
    .rdata       (c_rdata),
    .ctrl_status (ctrl_status),
    .ctrl_out    (ctrl_out)
  );

  // request decode: every request completes in a single cycle
  always_comb begin
    next_s      = s;
    next_s.done = (op != dbf_pkg::OP_NONE);
    unique case (op)
      // nothing requested
      dbf_pkg::OP_NONE: begin
        next_s.done = 1'b0;
      end
      // plain memory read, buffer nibbles included
      dbf_pkg::OP_MEM_READ: begin
        next_s.rdata = s.mem[addr];
      end
      // plain memory write, buffer nibbles included
      dbf_pkg::OP_MEM_WRITE: begin
        next_s.mem[addr] = wdata;
      end
      // peripheral into buffer; narrow fetch leaves the top byte alone
      dbf_pkg::OP_FETCH: begin
        next_s.mem[dbf_pkg::BUF_LMID_ADDR] = p_rdata[7:4];
        next_s.mem[dbf_pkg::BUF_LOW_ADDR]  = p_rdata[3:0];
        if (p_wide) begin
          next_s.mem[dbf_pkg::BUF_TOP_ADDR]  = p_rdata[15:12];
          next_s.mem[dbf_pkg::BUF_UMID_ADDR] = p_rdata[11:8];
        end
      end
      // buffer into peripheral, handled by the strobe
      dbf_pkg::OP_STORE: begin
        next_s.rdata = s.rdata;
      end
      // program word at the table pointer into the buffer
      dbf_pkg::OP_TABLE: begin
        next_s.mem[dbf_pkg::BUF_TOP_ADDR]  = rom_data[15:12];
        next_s.mem[dbf_pkg::BUF_UMID_ADDR] = rom_data[11:8];
        next_s.mem[dbf_pkg::BUF_LMID_ADDR] = rom_data[7:4];
        next_s.mem[dbf_pkg::BUF_LOW_ADDR]  = rom_data[3:0];
      end
      // register file into the window nibble
      dbf_pkg::OP_RF_READ: begin
        if (ctrl_hit) begin
          next_s.mem[dbf_pkg::WINDOW_ADDR] = c_rdata;
        end else begin
          next_s.mem[dbf_pkg::WINDOW_ADDR] = shared_val;
        end
      end
      // window nibble into the register file
      dbf_pkg::OP_RF_WRITE: begin
        if (!ctrl_hit) begin
          next_s.mem[addr] = s.mem[dbf_pkg::WINDOW_ADDR];
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{mem: {128{dbf_pkg::MEM_RESET}}, rdata: 4'h0, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flip-flops
  assign rdata           = s.rdata;
  assign done            = s.done;
  assign transfer_buffer = buf_val;

  // checks on the transfer behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // narrow fetch keeps the top byte
  a_fetch_keeps_top: assert property (
    (op == dbf_pkg::OP_FETCH) && !p_wide |=> transfer_buffer[15:8] == $past(buf_val[15:8]))
    else $error("narrow fetch changed the upper buffer byte");

  // narrow fetch loads the low byte from the peripheral
  a_fetch_low_byte: assert property (
    (op == dbf_pkg::OP_FETCH) && (addr == dbf_pkg::PA_SERIAL)
    |=> transfer_buffer[7:0] == $past(serial_shift_data))
    else $error("fetch did not load the serial byte");

  // wide fetch of the pointer zero-fills the upper six bits
  a_fetch_table_wide: assert property (
    (op == dbf_pkg::OP_FETCH) && (addr == dbf_pkg::PA_TABLE)
    |=> transfer_buffer == {6'h00, $past(table_pointer)})
    else $error("pointer fetch returned a wrong word");

  // wide store takes the low ten buffer bits
  a_store_table: assert property (
    (op == dbf_pkg::OP_STORE) && (addr == dbf_pkg::PA_TABLE)
    |=> table_pointer == $past(buf_val[9:0]))
    else $error("pointer store lost buffer bits");

  // narrow store takes only the low byte
  a_store_low_byte: assert property (
    (op == dbf_pkg::OP_STORE) && (addr == dbf_pkg::PA_RELOAD)
    |=> timer_reload_limit == $past(buf_val[7:0]))
    else $error("reload store took a wrong byte");

  // store to the fetch-only count changes nothing
  a_store_ro_nop: assert property (
    (op == dbf_pkg::OP_STORE) && (addr == dbf_pkg::PA_TIMER)
    |=> $stable(serial_shift_data) && $stable(timer_reload_limit) && $stable(table_pointer))
    else $error("store to the live count changed a register");

  // table lookup places the program word in the buffer
  a_table_load: assert property (
    (op == dbf_pkg::OP_TABLE) |=> transfer_buffer == $past(rom_data))
    else $error("table lookup did not load the program word");

  // shared register file view reads memory into the window
  a_register_file_read_op_shared: assert property (
    (op == dbf_pkg::OP_RF_READ) && !ctrl_hit
    |=> s.mem[dbf_pkg::WINDOW_ADDR] == $past(shared_val))
    else $error("shared register file read missed the memory cell");

  // write to a read-only control nibble leaves the area unchanged
  a_ctrl_ro_hold: assert property (
    c_we && CTRL_RO[addr[5:0]] |=> $stable(ctrl_out))
    else $error("read-only control nibble was written");

  // every request answers on the next edge, whatever its width
  a_done_pulse: assert property (
    (op != dbf_pkg::OP_NONE) |=> done ##1 (done == $past(op != dbf_pkg::OP_NONE)))
    else $error("request did not complete in one cycle");

  // memory write reaches a buffer nibble
  a_mem_buffer: assert property (
    (op == dbf_pkg::OP_MEM_WRITE) && (addr == dbf_pkg::BUF_LOW_ADDR)
    |=> transfer_buffer[3:0] == $past(wdata))
    else $error("memory write missed the low buffer nibble");

  // main scenarios
  c_fetch_wide:  cover property ((op == dbf_pkg::OP_FETCH) && p_wide);
  c_fetch_narrow: cover property ((op == dbf_pkg::OP_FETCH) && !p_wide);
  c_table_then_store: cover property ((op == dbf_pkg::OP_TABLE) ##1 (op == dbf_pkg::OP_STORE));
  c_register_file_write_op_ctrl:   cover property (c_we);

endmodule : dbf_core

/* design/dbf_ctrl_area.sv */
`timescale 1ns/1ps
module dbf_ctrl_area #(
  parameter logic [63:0] USED = dbf_pkg::CTRL_USED_DEF,  // nibbles that exist
  parameter logic [63:0] RO   = dbf_pkg::CTRL_RO_DEF     // nibbles that only read
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // access from the window
  input  wire logic         we,
  input  wire logic [5:0]   addr,
  input  wire logic [3:0]   wdata,
  output logic      [3:0]   rdata,
  // peripheral side
  input  wire logic [255:0] ctrl_status,
  output logic      [255:0] ctrl_out
);

  // state: one nibble per location
  typedef struct packed {
    logic [63:0][3:0] nib;
  } dbf_ctrl_st_t;

  dbf_ctrl_st_t s;       // registered state
  dbf_ctrl_st_t next_s;  // next state

  // refuse a map where a read-only nibble is not a used one
  if ((RO & ~USED) != 64'h0) begin : g_map_check
    $error("read-only control nibble outside the used map");
  end

  // write decode: read-only and unused nibbles keep their value
  always_comb begin
    next_s = s;
    for (int i = 0; i < 64; i++) begin
      if (we && (addr == 6'(i)) && USED[i] && !RO[i]) begin
        next_s.nib[i] = wdata;
      end
    end
  end

  // read mux: status for read-only, store for writable, fixed value for unused
  always_comb begin
    if (!USED[addr]) begin
      rdata = dbf_pkg::CTRL_UNDEF;
    end else if (RO[addr]) begin
      rdata = ctrl_status[{addr, 2'b00} +: 4];
    end else begin
      rdata = s.nib[addr];
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{nib: {64{dbf_pkg::CTRL_RESET}}};
    end else begin
      s <= next_s;
    end
  end

  assign ctrl_out = s.nib;

endmodule : dbf_ctrl_area

/* design/dbf_periph.sv */
`timescale 1ns/1ps
module dbf_periph (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // transfer port
  input  wire logic        we,
  input  wire logic [6:0]  addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             wide,
  // peripheral registers
  input  wire logic [7:0]  timer_live_count,
  output logic      [7:0]  serial_shift_data,
  output logic      [7:0]  timer_reload_limit,
  output logic      [9:0]  table_pointer
);

  // state of the writable peripheral registers
  typedef struct packed {
    logic [7:0] serial;
    logic [7:0] reload;
    logic [9:0] tp;
  } dbf_periph_st_t;

  dbf_periph_st_t s;       // registered state
  dbf_periph_st_t next_s;  // next state

  // store decode; the timer count is fetch-only so a store there does nothing
  always_comb begin
    next_s = s;
    if (we) begin
      unique case (addr)
        dbf_pkg::PA_SERIAL: next_s.serial = wdata[7:0];
        dbf_pkg::PA_RELOAD: next_s.reload = wdata[7:0];
        dbf_pkg::PA_TABLE:  next_s.tp     = wdata[9:0];
        default:            next_s        = s;
      endcase
    end
  end

  // fetch mux and transfer width
  always_comb begin
    wide  = (addr == dbf_pkg::PA_TABLE);
    rdata = dbf_pkg::FETCH_UNDEF;
    unique case (addr)
      dbf_pkg::PA_SERIAL: rdata = {8'h00, s.serial};
      dbf_pkg::PA_TIMER:  rdata = {8'h00, timer_live_count};
      dbf_pkg::PA_TABLE:  rdata = {6'h00, s.tp};
      default:            rdata = dbf_pkg::FETCH_UNDEF;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{serial: dbf_pkg::SERIAL_RESET, reload: dbf_pkg::RELOAD_RESET,
             tp: dbf_pkg::TABLE_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign serial_shift_data  = s.serial;
  assign timer_reload_limit = s.reload;
  assign table_pointer      = s.tp;

endmodule : dbf_periph

/* design/dbf_pkg.sv */
package dbf_pkg;

  // data memory and buffer geometry
  localparam int unsigned ADDR_W     = 7;             // nibble address width
  localparam int unsigned NIB_W      = 4;             // width of one memory cell
  localparam int unsigned MEM_DEPTH  = 128;           // nibbles in the first memory bank
  localparam int unsigned CTRL_DEPTH = 64;            // nibbles in the control area
  localparam int unsigned BUF_W      = 16;            // transfer buffer width
  localparam int unsigned BYTE_W     = 8;             // narrow peripheral width
  localparam int unsigned TABLE_W    = 10;            // effective table pointer bits

  // transfer buffer nibble addresses, most significant first
  localparam logic [6:0] BUF_TOP_ADDR   = 7'h0c;      // bits 15..12
  localparam logic [6:0] BUF_UMID_ADDR  = 7'h0d;      // bits 11..8
  localparam logic [6:0] BUF_LMID_ADDR  = 7'h0e;      // bits 7..4
  localparam logic [6:0] BUF_LOW_ADDR   = 7'h0f;      // bits 3..0

  // register file layout
  localparam logic [6:0] WINDOW_ADDR    = 7'h78;      // window nibble
  localparam logic [6:0] SHARED_BASE    = 7'h40;      // first nibble shared with memory

  // peripheral addresses
  localparam logic [6:0] PA_SERIAL      = 7'h01;      // serial_shift_data, store and fetch
  localparam logic [6:0] PA_TIMER       = 7'h02;      // timer_live_count, fetch only
  localparam logic [6:0] PA_RELOAD      = 7'h03;      // timer_reload_limit, store only
  localparam logic [6:0] PA_TABLE       = 7'h40;      // table_pointer, 16-bit

  // reset values
  localparam logic [3:0] MEM_RESET      = 4'h0;
  localparam logic [3:0] CTRL_RESET     = 4'h0;
  localparam logic [7:0] SERIAL_RESET   = 8'h00;
  localparam logic [7:0] RELOAD_RESET   = 8'h00;
  localparam logic [9:0] TABLE_RESET    = 10'h000;
  localparam logic [15:0] FETCH_UNDEF   = 16'h0000;   // answer of a store-only register
  localparam logic [3:0] CTRL_UNDEF     = 4'h0;       // answer of an unused control nibble

  // default control area map: used nibbles and the read-only ones among them
  localparam logic [63:0] CTRL_USED_DEF = 64'h000f_0000_00ff_00ff;
  localparam logic [63:0] CTRL_RO_DEF   = 64'h0008_0000_0080_0000;

  // requests from the cpu core
  typedef enum logic [2:0] {
    OP_NONE,       // idle
    OP_MEM_READ,   // data memory read
    OP_MEM_WRITE,  // data memory write
    OP_FETCH,      // peripheral_fetch into the buffer
    OP_STORE,      // buffer into a peripheral
    OP_TABLE,      // table_lookup_op
    OP_RF_READ,    // register_file_read_op into the window
    OP_RF_WRITE    // register_file_write_op from the window
  } dbf_op_t;

endpackage : dbf_pkg

/* dv/data_buffer_peripheral_transfer_tb.sv */
`timescale 1ns/1ps
module data_buffer_peripheral_transfer_tb;
  typedef struct packed {logic [2:0] k; logic [255:0] v;} dbf_note_t;  // one expected result
  localparam logic [2:0] K_NONE = 3'h0, K_RD = 3'h1, K_BUF = 3'h2, K_SER = 3'h3;
  localparam logic [2:0] K_REL = 3'h4, K_PTR = 3'h5, K_CTRL = 3'h6;
  logic                 clock;    // 20 mhz clock
  logic                 rst_b;    // async reset, active low
  dbf_pkg::dbf_op_t     op;       // request code
  logic [6:0]           addr;     // request address
  logic [3:0]           wdata;    // write nibble
  logic [3:0]           rdata;    // read answer
  logic                 done;     // completion pulse
  logic [7:0]           tlc;      // timer live count
  logic [7:0]           ser;      // serial shift data
  logic [7:0]           rel;      // timer reload limit
  logic [9:0]           ptr;      // table pointer
  logic [15:0]          rom;      // program word
  logic [255:0]         cst;      // control status in
  logic [255:0]         cout;     // control nibbles out
  logic [15:0]          tbuf;     // buffer view
  logic [3:0]           mem [128]; // shadow of data memory
  logic [255:0]         ctl;      // expected control nibbles
  dbf_note_t            notes[$]; // pending expectations
  int                   errors, checks_done, cycles, seed;

  dbf_core i_dbf_core (.clock(clock), .rst_b(rst_b), .op(op), .addr(addr), .wdata(wdata),
    .rdata(rdata), .done(done), .timer_live_count(tlc), .serial_shift_data(ser),
    .timer_reload_limit(rel), .table_pointer(ptr), .rom_data(rom), .ctrl_status(cst),
    .ctrl_out(cout), .transfer_buffer(tbuf));
  dbf_periph_model i_dbf_periph_model (.clock(clock), .rst_b(rst_b), .timer_live_count(tlc),
    .table_pointer(ptr), .rom_data(rom));

  // clock generation
  always #25 clock = ~clock;

  // compare and count
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // closing report
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // buffer as the shadow memory sees it
  function automatic logic [15:0] bufv();
    return {mem[12], mem[13], mem[14], mem[15]};
  endfunction : bufv

  // present one request at the falling edge and note its result
  task automatic req(input dbf_pkg::dbf_op_t o, input logic [6:0] a, input logic [3:0] d,
                     input logic [2:0] k, input logic [255:0] e);
    @(negedge clock);
    op = o;
    addr = a;
    wdata = d;
    notes.push_back({k, e});
  endtask : req

  // memory write with shadow update
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    req(dbf_pkg::OP_MEM_WRITE, a, d, K_NONE, '0);
    mem[a] = d;
  endtask : wr

  // memory read checked against the shadow
  task automatic rd(input logic [6:0] a);
    req(dbf_pkg::OP_MEM_READ, a, 4'h0, K_RD, 256'(mem[a]));
  endtask : rd

  // load the low byte of the shadow buffer
  task automatic set_low(input logic [7:0] v);
    mem[14] = v[7:4];
    mem[15] = v[3:0];
  endtask : set_low

  // monitor: every done pulse retires the oldest note
  always @(negedge clock) begin
    dbf_note_t n;
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        check(256'h1, 256'h0);
      end else begin
        n = notes.pop_front();
        case (n.k)
          K_RD:    check(256'(rdata), n.v);
          K_BUF:   check(256'(tbuf), n.v);
          K_SER:   check(256'(ser), n.v);
          K_REL:   check(256'(rel), n.v);
          K_PTR:   check(256'(ptr), n.v);
          K_CTRL:  check(cout, n.v);
          default: ;
        endcase
      end
    end
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  // main sequence
  initial begin
    logic [6:0] ra [4];
    logic [7:0] kept;
    logic [9:0] pv;    // pointer value last stored
    logic [3:0] d;
    clock = 1'b0;
    rst_b = 1'b0;
    op = dbf_pkg::OP_NONE;
    addr = 7'h00;
    wdata = 4'h0;
    seed = $urandom(78);
    for (int i = 0; i < 8; i++) begin
      cst[32*i+:32] = $urandom();
    end
    foreach (mem[i]) begin
      mem[i] = 4'h0;
    end
    ctl = '0;
    ra = '{7'h00, 7'h17, 7'h20, 7'h33};
    repeat (12) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    // buffer nibbles through ordinary memory access
    for (int i = 0; i < 4; i++) begin
      wr(7'(12 + i), 4'($urandom()));
    end
    for (int i = 0; i < 4; i++) begin
      rd(7'(12 + i));
    end
    req(dbf_pkg::OP_MEM_READ, 7'h0c, 4'h0, K_BUF, 256'(bufv()));
    // stores with different upper nibbles each round
    for (int r = 0; r < 2; r++) begin
      wr(7'h0c, 4'($urandom()));
      wr(7'h0d, 4'($urandom()));
      wr(7'h0f, 4'($urandom()));
      req(dbf_pkg::OP_STORE, 7'h01, 4'h0, K_SER, 256'(bufv()[7:0]));
      req(dbf_pkg::OP_STORE, 7'h03, 4'h0, K_REL, 256'(bufv()[7:0]));
      kept = bufv()[7:0];
      wr(7'h0e, ~mem[14]);
      req(dbf_pkg::OP_STORE, 7'h02, 4'h0, K_REL, 256'(kept));
      pv = bufv()[9:0];
      req(dbf_pkg::OP_STORE, 7'h40, 4'h0, K_PTR, 256'(pv));
    end
    // fetches back to back, upper byte must survive narrow ones
    set_low(bufv()[7:0] ^ 8'hff);
    wr(7'h0e, mem[14]);
    set_low(kept);
    req(dbf_pkg::OP_FETCH, 7'h01, 4'h0, K_BUF, 256'(bufv()));
    @(negedge clock);
    op = dbf_pkg::OP_FETCH;
    addr = 7'h02;
    set_low(tlc);
    notes.push_back({K_BUF, 256'(bufv())});
    req(dbf_pkg::OP_FETCH, 7'h40, 4'h0, K_BUF, 256'({6'h00, pv}));
    {mem[12], mem[13], mem[14], mem[15]} = {6'h00, pv};
    req(dbf_pkg::OP_FETCH, 7'h03, 4'h0, K_NONE, '0);
    rd(7'h0c);
    rd(7'h0d);
    // table lookup from the pointer
    {mem[12], mem[13], mem[14], mem[15]} = {pv[5:0], pv} ^ 16'hc35a;
    req(dbf_pkg::OP_TABLE, 7'h00, 4'h0, K_BUF, 256'(bufv()));
    // control area: writable, read-only, unused, read-only
    for (int i = 0; i < 4; i++) begin
      d = 4'($urandom());
      wr(7'h78, d);
      if (dbf_pkg::CTRL_USED_DEF[ra[i]] && !dbf_pkg::CTRL_RO_DEF[ra[i]]) begin
        ctl[4*ra[i]+:4] = d;
      end
      req(dbf_pkg::OP_RF_WRITE, ra[i], 4'h0, K_CTRL, ctl);
      req(dbf_pkg::OP_RF_READ, ra[i], 4'h0, K_NONE, '0);
      mem[120] = dbf_pkg::CTRL_RO_DEF[ra[i]] ? cst[4*ra[i]+:4] : d;
      if (dbf_pkg::CTRL_USED_DEF[ra[i]]) begin
        rd(7'h78);
      end else begin
        wr(7'h78, 4'h0);
      end
    end
    // upper register file half is data memory
    wr(7'h45, 4'($urandom()));
    req(dbf_pkg::OP_RF_READ, 7'h45, 4'h0, K_NONE, '0);
    mem[120] = mem[69];
    rd(7'h78);
    wr(7'h78, 4'($urandom()));
    req(dbf_pkg::OP_RF_WRITE, 7'h52, 4'h0, K_NONE, '0);
    mem[82] = mem[120];
    rd(7'h52);
    @(negedge clock) op = dbf_pkg::OP_NONE;
    repeat (3) @(negedge clock);
    check(256'(notes.size()), 256'h0);
    test_done();
  end
endmodule : data_buffer_peripheral_transfer_tb

/* dv/dbf_periph_model.sv */
`timescale 1ns/1ps
module dbf_periph_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // timer side
  output logic      [7:0]  timer_live_count,
  // program memory side
  input  wire logic [9:0]  table_pointer,
  output logic      [15:0] rom_data
);
  // live count steps by an odd amount so every bit moves
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timer_live_count <= 8'h00;
    end else begin
      timer_live_count <= timer_live_count + 8'h25;
    end
  end
  // program word depends on every pointer bit
  assign rom_data = {table_pointer[5:0], table_pointer} ^ 16'hc35a;
endmodule : dbf_periph_model
